// ---- rtl/gain_pos_ramp.sv ----
// Position-loop gain ramp: stepped rise, immediate fall
`timescale 1ns/10ps
module gain_pos_ramp
  import gain_switch_pkg::*;
#(
  parameter int unsigned GW = 16
)(
  // Clock and reset
  input  wire logic          aclk,
  input  wire logic          aresetn,
  // Targets
  input  wire logic [GW-1:0] target,
  input  wire logic [15:0]   ramp_time,
  input  wire logic          tick,
  // Result
  output logic [GW-1:0]      gain_q
);
  logic [GW-1:0] start_q;
  logic [GW-1:0] tgt_q;
  logic [15:0]   step_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      gain_q  <= '0;
      start_q <= '0;
      tgt_q   <= '0;
      step_q  <= '0;
    end
    else if (target != tgt_q)
    begin
      tgt_q   <= target;
      start_q <= gain_q;
      step_q  <= 16'h0000;
      if (target < gain_q || ramp_time == 16'h0000)
        gain_q <= target;  // [R21]
    end
    else if (gain_q < tgt_q && tick)
    begin
      // One step per tick  [R9]
      if (step_q + 16'h0001 >= ramp_time)
        gain_q <= tgt_q;
      else
        gain_q <= GW'(start_q + ((32'(tgt_q - start_q) * 32'(step_q + 16'h0001)) / 32'(ramp_time)));
      step_q <= step_q + 16'h0001;
    end
  end
endmodule // gain_pos_ramp

// ---- rtl/gain_switch_pkg.sv ----
// Gain selector constants and register map
package gain_switch_pkg;

  localparam int unsigned CLK_HZ             = 100_000_000;
  localparam int unsigned TICK_CYCLES        = (CLK_HZ / 10_000);
  localparam int unsigned TRQ_INTERVAL_US    = 166;
  localparam int unsigned TRQ_CYCLES         = (CLK_HZ / 1_000_000) * TRQ_INTERVAL_US;
  localparam int unsigned ALARM_RESET_MS     = 120;
  localparam int unsigned ALARM_RESET_DEF    = ALARM_RESET_MS * 10;  // in 0.1 ms steps
  localparam logic [15:0] SERVO_ON_SPEED_MAX = 16'h001E;       // 30 r/min

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL       = 8'h00;
  localparam logic [7:0] ADDR_COND       = 8'h04;
  localparam logic [7:0] ADDR_POS_DELAY  = 8'h08;
  localparam logic [7:0] ADDR_POS_LEVEL  = 8'h0C;
  localparam logic [7:0] ADDR_SPD_DELAY  = 8'h10;
  localparam logic [7:0] ADDR_SPD_LEVEL  = 8'h14;
  localparam logic [7:0] ADDR_TRQ_DELAY  = 8'h18;
  localparam logic [7:0] ADDR_TRQ_LEVEL  = 8'h1C;
  localparam logic [7:0] ADDR_RAMP       = 8'h20;
  localparam logic [7:0] ADDR_INPOS      = 8'h24;
  localparam logic [7:0] ADDR_ALMRST     = 8'h28;
  localparam logic [7:0] ADDR_STATUS     = 8'h2C;

  // CTRL fields
  localparam int unsigned CTRL_EN_BIT    = 0;
  localparam int unsigned CTRL_MODE_LSB  = 4;   // two bits: active control mode

  // COND fields (4 bits each)
  localparam int unsigned COND_POS_LSB   = 0;
  localparam int unsigned COND_SPD_LSB   = 8;
  localparam int unsigned COND_TRQ_LSB   = 16;

  localparam logic [1:0]  RESP_OKAY      = 2'b00;
  localparam logic [1:0]  RESP_SLVERR    = 2'b10;

  typedef enum logic [1:0] {CTL_POS, CTL_SPD, CTL_TRQ, CTL_RSV} ctl_mode_t;

  localparam logic [3:0] SW_ALWAYS1 = 4'h0;
  localparam logic [3:0] SW_ALWAYS2 = 4'h1;
  localparam logic [3:0] SW_EXT     = 4'h2;
  localparam logic [3:0] SW_TRQ     = 4'h3;
  localparam logic [3:0] SW_CMDSPD  = 4'h5;
  localparam logic [3:0] SW_PERR    = 4'h6;
  localparam logic [3:0] SW_CMDRX   = 4'h7;
  localparam logic [3:0] SW_INPOS   = 4'h8;
  localparam logic [3:0] SW_ACTSPD  = 4'h9;
  localparam logic [3:0] SW_COMBO   = 4'hA;

endpackage

// ---- rtl/servo_gain_set_selector.sv ----
// Gain set selector, servo interlock and registers
`timescale 1ns/10ps

// Contract
// R1 - Alarm reset input must hold for recognition time, default 120 ms.
// R2 - Servo-on refused while motor speed exceeds 30 r/min.
// R3 - After alarm clears, stay servo off until a fresh servo-on command.
// R4 - Brake interlock output follows only the brake release request.
// R5 - Global enable; disabled means no condition changes the gain set.
// R6 - Separate switching condition for position, speed and torque control.
// R7 - Return from secondary to primary delayed in 0.1 ms steps per mode.
// R8 - Quantity compared with level using hysteresis per mode.
// R9 - Position gain rises ramp over programmable 0.1 ms steps.
// R10 - Ramp applies only to position gain; others switch at once.
// R11 - Mode 2 follows external gain select input immediately.
// R12 - Mode 3 uses torque change per 166 us interval in 0.05% units.
// R13 - Torque change mode abandons pending switch when time not satisfied.
// R14 - Mode 5 uses commanded speed, mode 9 actual speed, in r/min.
// R15 - Mode 6 compares position error counter with level and hysteresis.
// R16 - Mode 7 switches while a position command of one unit arrives.
// R17 - Mode 8 selects secondary when error exceeds positioning range one.
// R18 - Mode 10 selects secondary as soon as a position command arrives.
// R19 - Mode 10 returns after no command for delay and speed below level-hyst; code uses the speed-control delay and returns at or below level-hyst.
// R20 - Host should disable realtime autotuning while gain switching is used.
// R21 - Falling position gain applies immediately, ignoring ramp time.
// R22 - Modes 0 and 1 fix primary or secondary set, ignoring other settings.
// R23 - Secondary at level; return delay starts below level minus hysteresis.
module servo_gain_set_selector
  import gain_switch_pkg::*;
#(
  parameter int unsigned GW = 16
)(
  // Clock and reset
  input  wire logic          aclk,
  input  wire logic          aresetn,
  // AXI4-Lite write
  input  wire logic [7:0]    s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]    s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  // Drive measurements
  input  wire logic [15:0]   torque_change,
  input  wire logic [15:0]   cmd_speed,
  input  wire logic [15:0]   motor_speed,
  input  wire logic [31:0]   pos_error,
  input  wire logic          pos_cmd_strobe,
  input  wire logic          external_gain_select_in,
  // Gain values
  input  wire logic [GW-1:0] pos_gain_primary,
  input  wire logic [GW-1:0] pos_gain_secondary,
  // Servo control
  input  wire logic          servo_on_cmd,
  input  wire logic          alarm_active,
  input  wire logic          alarm_reset_in,
  input  wire logic          brake_release_req,
  // Outputs
  output logic               gain_set_secondary_q,
  output logic [GW-1:0]      pos_gain_q,
  output logic               servo_on_q,
  output logic               alarm_clear_q,
  output logic               brake_interlock_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic        enable_q;
  ctl_mode_t   ctl_mode_q;
  logic [3:0]  cond_q [3];
  logic [15:0] delay_q [3];
  logic [15:0] level_q [3];
  logic [15:0] hyst_q [3];
  logic [15:0] ramp_q;
  logic [31:0] inpos_q;
  logic [15:0] alm_time_q;

  logic        aw_q;
  logic        w_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;

  logic        do_write;
  assign do_write = aw_q && w_q && !s_axi_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_q          <= 1'b0;
      w_q           <= 1'b0;
      awaddr_q      <= 8'h00;
      wdata_q       <= 32'h0000_0000;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end
    else
    begin
      s_axi_awready <= !aw_q && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_q     <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      else if (do_write)
        aw_q <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_q     <= 1'b1;
        wdata_q <= s_axi_wdata;
      end
      else if (do_write)
        w_q <= 1'b0;
    end
  end

  logic addr_ok;
  always_comb
  begin
    case (awaddr_q)
      ADDR_CTRL, ADDR_COND, ADDR_POS_DELAY, ADDR_POS_LEVEL, ADDR_SPD_DELAY, ADDR_SPD_LEVEL,
      ADDR_TRQ_DELAY, ADDR_TRQ_LEVEL, ADDR_RAMP, ADDR_INPOS, ADDR_ALMRST, ADDR_STATUS:
        addr_ok = 1'b1;
      default:
        addr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= addr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // Any nonzero strobe writes the whole word
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      enable_q   <= 1'b0;
      ctl_mode_q <= CTL_POS;
      ramp_q     <= 16'h0000;
      inpos_q    <= 32'h0000_000A;
      alm_time_q <= 16'(ALARM_RESET_DEF);  // [R1]
      for (int i = 0; i < 3; i++)
      begin
        cond_q[i]  <= SW_ALWAYS1;
        delay_q[i] <= 16'h0000;
        level_q[i] <= 16'h0000;
        hyst_q[i]  <= 16'h0000;
      end
    end
    else if (do_write && s_axi_wstrb != 4'h0)
    begin
      case (awaddr_q)
        ADDR_CTRL:
        begin
          enable_q   <= wdata_q[CTRL_EN_BIT];  // [R5]
          ctl_mode_q <= ctl_mode_t'(wdata_q[CTRL_MODE_LSB +: 2]);
        end
        ADDR_COND:
        begin
          cond_q[0] <= wdata_q[COND_POS_LSB +: 4];  // [R6]
          cond_q[1] <= wdata_q[COND_SPD_LSB +: 4];
          cond_q[2] <= wdata_q[COND_TRQ_LSB +: 4];
        end
        ADDR_POS_DELAY: delay_q[0] <= wdata_q[15:0];
        ADDR_SPD_DELAY: delay_q[1] <= wdata_q[15:0];
        ADDR_TRQ_DELAY: delay_q[2] <= wdata_q[15:0];
        ADDR_POS_LEVEL:
        begin
          level_q[0] <= wdata_q[15:0];
          hyst_q[0]  <= wdata_q[31:16];
        end
        ADDR_SPD_LEVEL:
        begin
          level_q[1] <= wdata_q[15:0];
          hyst_q[1]  <= wdata_q[31:16];
        end
        ADDR_TRQ_LEVEL:
        begin
          level_q[2] <= wdata_q[15:0];
          hyst_q[2]  <= wdata_q[31:16];
        end
        ADDR_RAMP:   ramp_q     <= wdata_q[15:0];
        ADDR_INPOS:  inpos_q    <= wdata_q;
        ADDR_ALMRST: alm_time_q <= wdata_q[15:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel
  logic [31:0] rd_word;
  always_comb
  begin
    case (s_axi_araddr)
      ADDR_CTRL:      rd_word = {26'h0, ctl_mode_q, 3'h0, enable_q};
      ADDR_COND:      rd_word = {12'h0, cond_q[2], 4'h0, cond_q[1], 4'h0, cond_q[0]};
      ADDR_POS_DELAY: rd_word = {16'h0, delay_q[0]};
      ADDR_SPD_DELAY: rd_word = {16'h0, delay_q[1]};
      ADDR_TRQ_DELAY: rd_word = {16'h0, delay_q[2]};
      ADDR_POS_LEVEL: rd_word = {hyst_q[0], level_q[0]};
      ADDR_SPD_LEVEL: rd_word = {hyst_q[1], level_q[1]};
      ADDR_TRQ_LEVEL: rd_word = {hyst_q[2], level_q[2]};
      ADDR_RAMP:      rd_word = {16'h0, ramp_q};
      ADDR_INPOS:     rd_word = inpos_q;
      ADDR_ALMRST:    rd_word = {16'h0, alm_time_q};
      ADDR_STATUS:    rd_word = {28'h0, brake_interlock_out, alarm_clear_q, servo_on_q, gain_set_secondary_q};
      default:        rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= (s_axi_araddr > ADDR_STATUS || s_axi_araddr[1:0] != 2'b00) ? RESP_SLVERR : RESP_OKAY;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // 0.1 ms tick and 166 us torque interval
  logic [31:0] tick_cnt_q;
  logic [31:0] trq_cnt_q;
  logic        tick;
  logic        trq_tick;
  assign tick     = (tick_cnt_q == 32'(TICK_CYCLES - 1));
  assign trq_tick = (trq_cnt_q == 32'(TRQ_CYCLES - 1));

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tick_cnt_q <= 32'h0000_0000;
      trq_cnt_q  <= 32'h0000_0000;
    end
    else
    begin
      tick_cnt_q <= tick ? 32'h0000_0000 : tick_cnt_q + 32'h0000_0001;
      trq_cnt_q  <= trq_tick ? 32'h0000_0000 : trq_cnt_q + 32'h0000_0001;
    end
  end

  // Rate held per interval; a rise back to level minus hysteresis cancels a pending return  [R12] [R13]
  logic [15:0] trq_rate_q;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      trq_rate_q <= 16'h0000;
    else if (trq_tick)
      trq_rate_q <= torque_change;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Gain decision for the active control mode
  logic [3:0]  cond;
  logic [15:0] lvl;
  logic [15:0] hys;
  logic [15:0] dly;
  logic [31:0] qty;
  logic        level_mode;
  logic        want2;
  logic        force_now;

  always_comb
  begin
    cond       = cond_q[ctl_mode_q == CTL_RSV ? 0 : int'(ctl_mode_q)];  // [R6]
    lvl        = level_q[ctl_mode_q == CTL_RSV ? 0 : int'(ctl_mode_q)];
    hys        = hyst_q[ctl_mode_q == CTL_RSV ? 0 : int'(ctl_mode_q)];
    dly        = delay_q[ctl_mode_q == CTL_RSV ? 0 : int'(ctl_mode_q)];
    qty        = 32'h0000_0000;
    level_mode = 1'b0;
    want2      = 1'b0;
    force_now  = 1'b1;
    case (cond)
      SW_ALWAYS2: want2 = 1'b1;  // [R22]
      SW_EXT:     want2 = external_gain_select_in;  // [R11]
      SW_TRQ:
      begin
        qty        = {16'h0, trq_rate_q};  // [R12]
        level_mode = 1'b1;
      end
      SW_CMDSPD, SW_ACTSPD:
      begin
        qty        = {16'h0, (cond == SW_CMDSPD) ? cmd_speed : motor_speed};  // [R14]
        level_mode = 1'b1;
      end
      SW_PERR:
      begin
        qty        = pos_error;  // [R15]
        level_mode = 1'b1;
      end
      SW_CMDRX:   want2 = pos_cmd_strobe;  // [R16]
      SW_INPOS:   want2 = pos_error > inpos_q;  // [R17]
      SW_COMBO:
      begin
        qty        = {16'h0, motor_speed};
        level_mode = 1'b1;
      end
      default:    want2 = 1'b0;  // [R22]
    endcase
    if (level_mode)
      force_now = 1'b0;
    if (ctl_mode_q != CTL_POS && cond > SW_TRQ && !(ctl_mode_q == CTL_SPD && cond == SW_CMDSPD))
    begin
      want2      = 1'b0;
      level_mode = 1'b0;
      force_now  = 1'b1;
    end
  end

  // Hysteresis thresholds  [R8] [R23]
  logic above;
  logic below;
  assign above = qty >= {16'h0, lvl};
  assign below = ({16'h0, lvl} < {16'h0, hys}) ? 1'b0 : (qty < ({16'h0, lvl} - {16'h0, hys}));

  logic [15:0] ret_cnt_q;
  logic [15:0] idle_cnt_q;

  // Command idle time for the combined mode
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      idle_cnt_q <= 16'h0000;
    else if (pos_cmd_strobe)
      idle_cnt_q <= 16'h0000;
    else if (tick && idle_cnt_q != 16'hFFFF)
      idle_cnt_q <= idle_cnt_q + 16'h0001;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      gain_set_secondary_q <= 1'b0;
      ret_cnt_q            <= 16'h0000;
    end
    else if (!enable_q)
      ret_cnt_q <= 16'h0000;  // [R5]
    else if (force_now)
    begin
      gain_set_secondary_q <= want2;  // [R10]
      ret_cnt_q            <= 16'h0000;
    end
    else if (cond == SW_COMBO)
    begin
      if (pos_cmd_strobe)
        gain_set_secondary_q <= 1'b1;  // [R18]
      else if (idle_cnt_q >= delay_q[1] && (({16'h0, lvl} < {16'h0, hys}) || !(qty > {16'h0, lvl} - {16'h0, hys})))
        gain_set_secondary_q <= 1'b0;  // [R19]
    end
    else if (above)
    begin
      gain_set_secondary_q <= 1'b1;  // [R23]
      ret_cnt_q            <= 16'h0000;
    end
    else if (gain_set_secondary_q && below)
    begin
      if (ret_cnt_q >= dly)
        gain_set_secondary_q <= 1'b0;  // [R7]
      else if (tick)
        ret_cnt_q <= ret_cnt_q + 16'h0001;
    end
    else
      ret_cnt_q <= 16'h0000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Position gain ramp
  gain_pos_ramp #(.GW(GW)) u_ramp (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .target    (gain_set_secondary_q ? pos_gain_secondary : pos_gain_primary),
    .ramp_time (ramp_q),
    .tick      (tick),
    .gain_q    (pos_gain_q)
  );  // [R9] [R10]

  ////////////////////////////////////////////////////////////////////////////
  // Alarm reset recognition and servo-on interlock
  logic [15:0] alm_cnt_q;
  logic        need_off_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      alm_cnt_q     <= 16'h0000;
      alarm_clear_q <= 1'b0;
    end
    else
    begin
      alarm_clear_q <= 1'b0;
      if (!alarm_reset_in)
        alm_cnt_q <= 16'h0000;
      else if (alm_cnt_q >= alm_time_q)
      begin
        alarm_clear_q <= alarm_active;  // [R1]
        alm_cnt_q     <= 16'h0000;
      end
      else if (tick)
        alm_cnt_q <= alm_cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      servo_on_q <= 1'b0;
      need_off_q <= 1'b0;
    end
    else if (alarm_active || alarm_clear_q)
    begin
      servo_on_q <= 1'b0;
      need_off_q <= 1'b1;  // [R3]
    end
    else if (!servo_on_cmd)
    begin
      servo_on_q <= 1'b0;
      need_off_q <= 1'b0;
    end
    else if (!need_off_q && motor_speed <= SERVO_ON_SPEED_MAX)
      servo_on_q <= 1'b1;  // [R2]
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      brake_interlock_out <= 1'b0;
    else
      brake_interlock_out <= brake_release_req;  // [R4]
  end

endmodule // servo_gain_set_selector

// ---- testbench/host_drive_model.sv ----
// Host model driving the selector's inputs
`timescale 1ns/10ps
module host_drive_model (
  // Drive inputs of the selector
  output logic        external_gain_select_in = 1'b0,
  output logic        pos_cmd_strobe = 1'b0,
  output logic        servo_on_cmd = 1'b0,
  output logic        alarm_active = 1'b0,
  output logic        alarm_reset_in = 1'b0,
  output logic        brake_release_req = 1'b0,
  output logic [15:0] motor_speed = 16'h0000,
  output logic [15:0] cmd_speed = 16'h0000,
  output logic [15:0] torque_change = 16'h0000,
  output logic [31:0] pos_error = 32'h0000_0000
);
  // Autotuning off while switching
  localparam logic [3:0] realtime_autotune_select = 4'h0;

  ////////////////////////////////////////
  // Call just after a rising edge
  task automatic drive(input logic g, s, a, r, b, input logic [15:0] spd);
    external_gain_select_in <= g;
    servo_on_cmd            <= s;
    alarm_active            <= a;
    alarm_reset_in          <= r;
    brake_release_req       <= b;
    motor_speed             <= spd;
  endtask
endmodule // host_drive_model

// ---- testbench/servo_gain_set_selector_assertions.sv ----
// Port checker for the gain set selector
`timescale 1ns/10ps
module gain_sel_checker
#(
  parameter int unsigned GW = 16
)(
  // Clock and reset
  input wire logic          aclk,
  input wire logic          aresetn,
  // Watched ports
  input wire logic [15:0]   motor_speed,
  input wire logic          servo_on_cmd,
  input wire logic          alarm_reset_in,
  input wire logic          brake_release_req,
  input wire logic [GW-1:0] pos_gain_primary,
  input wire logic [GW-1:0] pos_gain_secondary,
  input wire logic          gain_set_secondary_q,
  input wire logic [GW-1:0] pos_gain_q,
  input wire logic          servo_on_q,
  input wire logic          alarm_clear_q,
  input wire logic          brake_interlock_out
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  brake_follow_a: assert property (
    brake_interlock_out |-> $past(brake_release_req)) else $error("brake output without request");
  speed_gate_a: assert property (
    $rose(servo_on_q) |-> $past(motor_speed) <= 16'h001E) else $error("servo on above speed limit");
  fresh_cmd_a: assert property (
    $rose(servo_on_q) |-> $past(servo_on_cmd)) else $error("servo on without command");
  clear_off_a: assert property (
    alarm_clear_q |=> !servo_on_q) else $error("servo on right after alarm clear");
  clear_pulse_a: assert property (
    alarm_clear_q |=> !alarm_clear_q) else $error("alarm clear longer than one cycle");
  clear_hold_a: assert property (
    alarm_clear_q |-> $past(alarm_reset_in) && $past(alarm_reset_in, 8)) else $error("alarm clear too early");
  gain_fall_a: assert property (
    pos_gain_q < $past(pos_gain_q) |-> pos_gain_q == pos_gain_primary || pos_gain_q == pos_gain_secondary)
    else $error("gain fell in steps");
  fall_now_a: assert property (
    $fell(gain_set_secondary_q) && pos_gain_primary < pos_gain_secondary |-> ##[0:2] pos_gain_q == pos_gain_primary)
    else $error("gain fall delayed");

  cover property ($rose(gain_set_secondary_q));
  cover property ($rose(servo_on_q));
  cover property (alarm_clear_q);
endmodule // gain_sel_checker

bind servo_gain_set_selector gain_sel_checker #(.GW(GW)) u_chk (
  .aclk, .aresetn, .motor_speed, .servo_on_cmd, .alarm_reset_in, .brake_release_req, .pos_gain_primary,
  .pos_gain_secondary, .gain_set_secondary_q, .pos_gain_q, .servo_on_q, .alarm_clear_q, .brake_interlock_out
);

// ---- testbench/servo_gain_set_selector_test.sv ----
// Self-checking bench for the gain set selector
`timescale 1ns/10ps
module servo_gain_set_selector_test;
  import gain_switch_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [15:0] torque_change, cmd_speed, motor_speed, pos_gain_q;
  logic [15:0] pos_gain_primary = 16'h000A, pos_gain_secondary = 16'h0032;
  logic [31:0] pos_error;
  logic pos_cmd_strobe, external_gain_select_in, servo_on_cmd, alarm_active, alarm_reset_in, brake_release_req;
  logic gain_set_secondary_q, servo_on_q, alarm_clear_q, brake_interlock_out;
  int num_errors = 0;
  int n_tests = 0;

  always #5 aclk = ~aclk;

  servo_gain_set_selector DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .torque_change,
    .cmd_speed, .motor_speed, .pos_error, .pos_cmd_strobe, .external_gain_select_in, .pos_gain_primary,
    .pos_gain_secondary, .servo_on_cmd, .alarm_active, .alarm_reset_in, .brake_release_req,
    .gain_set_secondary_q, .pos_gain_q, .servo_on_q, .alarm_clear_q, .brake_interlock_out);

  host_drive_model host (.external_gain_select_in, .pos_cmd_strobe, .servo_on_cmd, .alarm_active,
    .alarm_reset_in, .brake_release_req, .motor_speed, .cmd_speed, .torque_change, .pos_error);

  ////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // Both channels offered at once
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
    int n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1 && n < 64);
    s_axi_bready <= 1'b0;
    chk("bresp", 32'(resp), n < 64 ? 32'(s_axi_bresp) : 32'h0000_0004);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
    int n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1 && n < 64);
    s_axi_rready <= 1'b0;
    chk("rdata", d, s_axi_rdata);
    chk("rresp", 32'(resp), n < 64 ? 32'(s_axi_rresp) : 32'h0000_0004);
  endtask

  task automatic hold(input int n, output bit seen);
    seen = 1'b0;
    repeat (n)
    begin
      @(posedge aclk);
      if (alarm_clear_q === 1'b1)
        seen = 1'b1;
    end
  endtask

  ////////////////////////////////////////
  initial
  begin
    repeat (90000) @(posedge aclk);
    num_errors++;
    $display("BAD watchdog expected finish seen timeout");
    summarize();
  end

  initial
  begin
    bit seen;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ADDR_CTRL, 32'h0000_0000, RESP_OKAY);
    rd(ADDR_ALMRST, 32'h0000_04B0, RESP_OKAY);
    rd(ADDR_INPOS, 32'h0000_000A, RESP_OKAY);
    rd(8'h30, 32'h0000_0000, RESP_SLVERR);
    wr(8'h34, 32'h0000_0001, RESP_SLVERR);
    // Fixed sets: ramped rise, instant fall
    wr(ADDR_RAMP, 32'h0000_0002, RESP_OKAY);
    wr(ADDR_CTRL, 32'h0000_0001, RESP_OKAY);
    wr(ADDR_COND, 32'h0000_0001, RESP_OKAY);
    cyc(3);
    chk("set", 32'h1, 32'(gain_set_secondary_q));
    chk("ramp_done", 32'h0, 32'(pos_gain_q == pos_gain_secondary));
    cyc(21000);
    chk("gain", 32'h0000_0032, 32'(pos_gain_q));
    wr(ADDR_COND, 32'h0000_0000, RESP_OKAY);
    cyc(3);
    chk("set", 32'h0, 32'(gain_set_secondary_q));
    chk("gain", 32'h0000_000A, 32'(pos_gain_q));
    wr(ADDR_RAMP, 32'h0000_0000, RESP_OKAY);
    // External select and brake follow at once
    wr(ADDR_COND, 32'h0000_0002, RESP_OKAY);
    for (int i = 1; i >= 0; i--)
    begin
      host.drive(i[0], 1'b0, 1'b0, 1'b0, i[0], 16'h0000);
      cyc(3);
      chk("set", 32'(i[0]), 32'(gain_set_secondary_q));
      chk("brake", 32'(i[0]), 32'(brake_interlock_out));
    end
    wr(ADDR_CTRL, 32'h0000_0000, RESP_OKAY);
    host.drive(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0000);
    cyc(3);
    chk("set", 32'h0, 32'(gain_set_secondary_q));
    host.drive(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0000);
    wr(ADDR_CTRL, 32'h0000_0001, RESP_OKAY);
    // Actual speed: level 100, hysteresis 20, delay two ticks
    wr(ADDR_POS_DELAY, 32'h0000_0002, RESP_OKAY);
    wr(ADDR_POS_LEVEL, 32'h0014_0064, RESP_OKAY);
    wr(ADDR_COND, 32'h0000_0109, RESP_OKAY);
    host.drive(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 16'h0064);
    cyc(3);
    chk("set", 32'h1, 32'(gain_set_secondary_q));
    chk("servo", 32'h0, 32'(servo_on_q));
    host.drive(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 16'h005A);
    cyc(3000);
    chk("set", 32'h1, 32'(gain_set_secondary_q));
    host.drive(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 16'h0046);
    cyc(3);
    chk("set", 32'h1, 32'(gain_set_secondary_q));
    cyc(21000);
    chk("set", 32'h0, 32'(gain_set_secondary_q));
    wr(ADDR_CTRL, 32'h0000_0011, RESP_OKAY);
    cyc(3);
    chk("set", 32'h1, 32'(gain_set_secondary_q));
    wr(ADDR_CTRL, 32'h0000_0001, RESP_OKAY);
    // Servo interlock, alarm reset of two ticks
    host.drive(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 16'h000A);
    cyc(3);
    chk("servo", 32'h1, 32'(servo_on_q));
    wr(ADDR_ALMRST, 32'h0000_0002, RESP_OKAY);
    host.drive(1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 16'h000A);
    hold(5000, seen);
    chk("early_clear", 32'h0, 32'(seen));
    host.drive(1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 16'h000A);
    cyc(2);
    host.drive(1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 16'h000A);
    hold(21000, seen);
    chk("clear", 32'h1, 32'(seen));
    host.drive(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 16'h000A);
    cyc(5);
    chk("servo", 32'h0, 32'(servo_on_q));
    host.drive(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 16'h000A);
    cyc(3);
    host.drive(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 16'h000A);
    cyc(5);
    chk("servo", 32'h1, 32'(servo_on_q));
    summarize();
  end
endmodule // servo_gain_set_selector_test
